// >>> mbsa_arbiter.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mbsa_map.svh"
module mbsa_arbiter #(
   parameter int NM = 6,
   parameter int NS = 5,
   parameter logic [NM-1:0] CONNECTED = 6'h3f
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire mbsa_pkg::mbsa_req_s     slaveReq [NS],
   output mbsa_pkg::mbsa_grant_s        slaveGrant [NS],
   output logic [NM-1:0]                burstEnd [NS],
   output logic [1:0]                   remapEnable
);
   import mbsa_pkg::*;

   logic [31:0] mcfg_r [NM];
   logic [31:0] scfg_r [NS];
   logic [31:0] prs_r  [NS];
   logic [31:0] mrcr_r;
   logic        wrPend_r;
   logic [11:0] wrAddr_r;
   logic [31:0] rdNxt;

   wire accessOk = hsel && hready && htrans[1];
   wire [11:0] aOff = {haddr[11:2], 2'b00};

   // registers are zero-wait: write data is taken in the data phase
   always_ff @(posedge clk) begin
      if (reset) begin
         wrPend_r  <= 1'b0;
         wrAddr_r  <= 12'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wrPend_r <= accessOk && hwrite;
         wrAddr_r <= aOff;
         if (accessOk && !hwrite)
            hrdata <= rdNxt;
      end
   end

   // read mux: unmapped words read zero with an okay response
   always_comb begin
      rdNxt = 32'h00000000;
      for (int i = 0; i < NM; i++)
         if (aOff == `MBSA_MCFG_BASE + 12'(4*i))
            rdNxt = mcfg_r[i];
      for (int i = 0; i < NS; i++) begin
         if (aOff == `MBSA_SCFG_BASE + 12'(4*i))
            rdNxt = scfg_r[i];
         if (aOff == `MBSA_PRS_BASE + 12'(8*i))
            rdNxt = prs_r[i];
      end
      if (aOff == `MBSA_MRCR_ADDR)
         rdNxt = mrcr_r;
   end

   always_ff @(posedge clk) begin
      if (reset)
         mrcr_r <= `MBSA_MRCR_RESET;
      else if (wrPend_r && wrAddr_r == `MBSA_MRCR_ADDR)
         mrcr_r <= hwdata & `MBSA_MRCR_MASK;
   end

   always_ff @(posedge clk) begin
      if (reset)
         remapEnable <= 2'b00;
      else
         remapEnable <= mrcr_r[1:0];
   end

   genvar gm;
   generate
      for (gm = 0; gm < NM; gm++) begin : gMcfg
         always_ff @(posedge clk) begin
            if (reset)
               mcfg_r[gm] <= `MBSA_MCFG_RESET;
            else if (wrPend_r && wrAddr_r == `MBSA_MCFG_BASE + 12'(4*gm))
               mcfg_r[gm] <= hwdata & `MBSA_MCFG_MASK;
         end
      end
   endgenerate

   genvar gs;
   generate
      for (gs = 0; gs < NS; gs++) begin : gSlave
         mbsa_state_e    st_r;
         logic [2:0]     own_r;
         logic [2:0]     last_r;
         logic [7:0]     slot_r;
         logic [4:0]     beats_r;
         logic [NM-1:0]  pend;
         logic [NM-1:0]  predEnd;
         logic [2:0]     rrPick;
         logic [2:0]     fpPick;
         logic           anyReq;
         logic           rearb;
         logic [2:0]     pick;
         logic [4:0]     chunk;
         wire [1:0] defType = scfg_r[gs][`MBSA_DEFT_LSB +: 2];
         wire [2:0] fixM    = scfg_r[gs][`MBSA_FIXM_LSB +: 3];
         wire [1:0] arbType = scfg_r[gs][`MBSA_ARBITRATION_TYPE_LSB +: 2];
         wire [7:0] slotMax = scfg_r[gs][`MBSA_SLOT_LSB +: 8];
         wire [2:0] undefined_length_burst_split    = mcfg_r[own_r][`MBSA_UNDEFINED_LENGTH_BURST_SPLIT_LSB +: 3];
         wire       owned   = (st_r == MBSA_OWNED);

         always_ff @(posedge clk) begin
            if (reset)
               scfg_r[gs] <= `MBSA_SCFG_RESET;
            else if (wrPend_r && wrAddr_r == `MBSA_SCFG_BASE + 12'(4*gs))
               scfg_r[gs] <= hwdata & `MBSA_SCFG_MASK;
         end
         always_ff @(posedge clk) begin
            if (reset)
               prs_r[gs] <= `MBSA_PRS_RESET;
            else if (wrPend_r && wrAddr_r == `MBSA_PRS_BASE + 12'(8*gs))
               prs_r[gs] <= hwdata & `MBSA_PRS_MASK;
         end

         assign pend = slaveReq[gs].req & CONNECTED;
         assign anyReq = |pend;

         // chunk length per split code; 0 means never split
         always_comb begin
            case (undefined_length_burst_split)
               3'd1:    chunk = 5'd1;
               3'd2:    chunk = 5'd4;
               3'd3:    chunk = 5'd8;
               3'd4:    chunk = 5'd16;
               default: chunk = 5'd0;
            endcase
         end

         always_comb begin
            predEnd = '0;
            if (owned && slaveReq[gs].incr[own_r] && chunk != 5'd0 &&
                slaveReq[gs].beat[own_r] && beats_r + 5'd1 == chunk)
               predEnd[own_r] = 1'b1;
         end

         // rotation starts after the last owner; from reset that is NM-1, so master 0 comes first
         always_comb begin
            rrPick = 3'd0;
            for (int k = NM; k >= 1; k--) begin
               int idx;
               idx = (int'(last_r) + k) % NM;
               if (pend[idx])
                  rrPick = 3'(idx);
            end
         end

         // ties go to the later index since >= keeps replacing
         always_comb begin
            logic [1:0] best;
            best = 2'd0;
            fpPick = 3'd0;
            for (int k = 0; k < NM; k++)
               if (pend[k] && prs_r[gs][4*k +: 2] >= best) begin
                  best = prs_r[gs][4*k +: 2];
                  fpPick = 3'(k);
               end
         end

         assign pick = (arbType == 2'd1) ? fpPick : rrPick;

         // a zero slot count disables the limit
         assign rearb = !owned || !pend[own_r] ||
            slaveReq[gs].single[own_r] || slaveReq[gs].last[own_r] ||
            (|predEnd) ||
            (slotMax != 8'd0 && slot_r == 8'd0 &&
             slaveReq[gs].beat[own_r]);

         always_ff @(posedge clk) begin
            if (reset) begin
               st_r    <= MBSA_IDLE;
               own_r   <= 3'd0;
               last_r  <= 3'(NM - 1);
               slot_r  <= 8'd0;
               beats_r <= 5'd0;
            end else if (rearb && anyReq) begin
               st_r    <= MBSA_OWNED;
               own_r   <= pick;
               last_r  <= pick;
               slot_r  <= slotMax;
               beats_r <= 5'd0;
            end else if (rearb) begin
               case (defType)
                  2'd1: begin
                     st_r <= owned ? MBSA_PARK : st_r;
                  end
                  2'd2: begin
                     if (fixM < 3'(NM) && CONNECTED[fixM]) begin
                        st_r  <= MBSA_PARK;
                        own_r <= fixM;
                     end else
                        st_r <= MBSA_IDLE;
                  end
                  default: st_r <= MBSA_IDLE;
               endcase
               beats_r <= 5'd0;
            end else begin
               if (slot_r != 8'd0)
                  slot_r <= slot_r - 8'd1;
               if (slaveReq[gs].beat[own_r])
                  beats_r <= beats_r + 5'd1;
            end
         end

         // parked owner shows as granted so its first beat has no wait
         always_ff @(posedge clk) begin
            if (reset) begin
               slaveGrant[gs] <= '0;
               burstEnd[gs]   <= '0;
            end else begin
               slaveGrant[gs].valid  <= (st_r != MBSA_IDLE);
               slaveGrant[gs].master <= own_r;
               burstEnd[gs]          <= predEnd;
            end
         end
      end
   endgenerate
endmodule // mbsa_arbiter

// >>> mbsa_arbiter_monitor.sv
`timescale 1ns/1ps
module mbsa_arbiter_monitor #(
   parameter int NM = 6,
   parameter int NS = 5
) (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  hsel,
   input wire logic [31:0]           haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic [31:0]           hrdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire mbsa_pkg::mbsa_req_s   slaveReq [NS],
   input wire mbsa_pkg::mbsa_grant_s slaveGrant [NS],
   input wire logic [NM-1:0]         burstEnd [NS],
   input wire logic [1:0]            remapEnable
);
   import mbsa_pkg::*;
   logic wrMap_r;
   always_ff @(posedge clk)
      wrMap_r <= hsel && hready && htrans[1] && hwrite &&
                 haddr[11:0] == 12'h100;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ok_resp_a: assert property (hresp == 1'b0) else $error("bad response");
   zero_wait_a: assert property (hreadyout) else $error("wait state seen");
   reset_clean_a: assert property ($past(reset) |-> !slaveGrant[0].valid
      && burstEnd[0] == '0 && remapEnable == 2'h0) else $error("reset values");
   remap_write_a:
      assert property ($changed(remapEnable) |-> $past(wrMap_r)
         || $past(wrMap_r, 2)) else $error("remap changed without write");
   read_hold_a: assert property ($changed(hrdata) |->
      $past(hsel && hready && htrans[1] && !hwrite)) else $error("rdata moved");
   burst_end_a:
      assert property ((burstEnd[0] & ~$past(slaveReq[0].incr)) == '0)
         else $error("burst end without incr");
   grant_range_a: assert property (slaveGrant[0].valid
      |-> slaveGrant[0].master <= 3'h5) else $error("grant out of range");
   grant_serve_a:
      assert property (slaveReq[0].req[1] [*3] |-> slaveGrant[0].valid)
         else $error("requester left without grant");
endmodule // mbsa_arbiter_monitor
bind mbsa_arbiter mbsa_arbiter_monitor #(.NM(NM), .NS(NS))
   i_mbsa_arbiter_monitor (.clk(clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .slaveReq(slaveReq), .slaveGrant(slaveGrant), .burstEnd(burstEnd),
   .remapEnable(remapEnable));

// >>> mbsa_map.svh
`ifndef MBSA_MAP_SVH
`define MBSA_MAP_SVH
`define MBSA_MCFG_BASE    12'h000
`define MBSA_SCFG_BASE    12'h040
`define MBSA_PRS_BASE     12'h080
`define MBSA_MRCR_ADDR    12'h100
`define MBSA_UNDEFINED_LENGTH_BURST_SPLIT_LSB     0
`define MBSA_SLOT_LSB     0
`define MBSA_DEFT_LSB     16
`define MBSA_FIXM_LSB     18
`define MBSA_ARBITRATION_TYPE_LSB     24
`define MBSA_MCFG_RESET   32'h00000000
`define MBSA_SCFG_RESET   32'h00000010
`define MBSA_PRS_RESET    32'h00000000
`define MBSA_MRCR_RESET   32'h00000000
`define MBSA_MCFG_MASK    32'h00000007
`define MBSA_SCFG_MASK    32'h031f00ff
`define MBSA_PRS_MASK     32'h00333333
`define MBSA_MRCR_MASK    32'h00000003
`endif

// >>> mbsa_master_model.sv
`timescale 1ns/1ps
module mbsa_master_model #(
   parameter int NS = 5
) (
   input  wire logic                  clk,
   input  wire logic [5:0]            wantReq,
   input  wire logic [5:0]            wantIncr,
   input  wire logic                  slow,
   input  wire mbsa_pkg::mbsa_grant_s slaveGrant [NS],
   output mbsa_pkg::mbsa_req_s        slaveReq [NS]
);
   import mbsa_pkg::*;
   logic       phase_r = 1'b0;
   logic [5:0] owner;
   always_ff @(posedge clk) phase_r <= ~phase_r;
   // a slow master only completes a beat every other cycle
   assign owner = slaveGrant[0].valid ? 6'h1 << slaveGrant[0].master : 6'h0;
   always_comb begin
      for (int s = 0; s < NS; s++) slaveReq[s] = '0;
      slaveReq[0].req = wantReq;
      slaveReq[0].incr = wantIncr & wantReq;
      slaveReq[0].beat = wantIncr & wantReq & owner & {6{phase_r | ~slow}};
   end
endmodule // mbsa_master_model

// >>> mbsa_pkg.sv
package mbsa_pkg;
   typedef enum logic [1:0] {
      MBSA_IDLE  = 2'b00,
      MBSA_OWNED = 2'b01,
      MBSA_PARK  = 2'b11
   } mbsa_state_e;
   typedef struct packed {
      logic [5:0] req;
      logic [5:0] single;
      logic [5:0] incr;
      logic [5:0] last;
      logic [5:0] beat;
   } mbsa_req_s;
   typedef struct packed {
      logic       valid;
      logic [2:0] master;
   } mbsa_grant_s;
endpackage

// >>> test_mbsa_arbiter.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t: got %h want %h", $time, a, b); end end
module test_mbsa_arbiter;
   import mbsa_pkg::*;
   logic        clk = 1'b0;
   logic        reset, hsel, hwrite, slow, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, remapEnable;
   logic [2:0]  hsize;
   logic [5:0]  wantReq, wantIncr;
   mbsa_req_s   slaveReq [5];
   mbsa_grant_s slaveGrant [5];
   logic [5:0]  burstEnd [5];
   int          err_count, n_checks, nb, np;
   int          expEnd [5] = '{0, 16, 4, 2, 1};
   assign hready = hreadyout;
   always #4 clk = ~clk;
   // master 5 left unconnected to reach the fallback of a bad default
   mbsa_arbiter #(.CONNECTED(6'h1f)) i_mbsa_arbiter (.clk(clk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .slaveReq(slaveReq), .slaveGrant(slaveGrant), .burstEnd(burstEnd),
      .remapEnable(remapEnable));
   mbsa_master_model i_mbsa_master_model (.clk(clk), .wantReq(wantReq),
      .wantIncr(wantIncr), .slow(slow), .slaveGrant(slaveGrant),
      .slaveReq(slaveReq));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hold();
      int k;
      k = 0;
      do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin err_count++; report_and_stop(); end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a};
      hold();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      hold();
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic gnt(input logic [5:0] r, input logic v, input logic [2:0] m);
      logic [3:0] g;
      wantReq <= r;
      for (int k = 0; k < 12; k++) begin
         @(posedge clk);
         g = {slaveGrant[0].valid, slaveGrant[0].master & {3{slaveGrant[0].valid}}};
         if (g === {v, m}) break;
      end
      `CHK(g, {v, m})
   endtask
   initial begin
      reset = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; wantReq = '0; wantIncr = '0; slow = 1'b0;
      err_count = 0; n_checks = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rdc(12'h040, 32'h10);
      rdc(12'h018, 32'h0);
      rdc(12'h080, 32'h0);
      wr(12'h100, 32'hffffffff);
      rdc(12'h100, 32'h3);
      `CHK(remapEnable, 2'h3)
      wr(12'h100, 32'h2);
      // remap output follows the register one clock later
      repeat (2) @(posedge clk);
      `CHK(remapEnable, 2'h2)
      gnt(6'h0a, 1'b1, 3'h1);
      gnt(6'h08, 1'b1, 3'h3);
      gnt(6'h00, 1'b0, 3'h0);
      wr(12'h040, 32'h01000010);
      wr(12'h080, 32'h20);
      gnt(6'h0a, 1'b1, 3'h1);
      gnt(6'h00, 1'b0, 3'h0);
      wr(12'h080, 32'h0);
      gnt(6'h0a, 1'b1, 3'h3);
      wr(12'h040, 32'h00010010);
      gnt(6'h04, 1'b1, 3'h2);
      gnt(6'h00, 1'b1, 3'h2);
      wr(12'h040, 32'h00120010);
      gnt(6'h00, 1'b1, 3'h4);
      wr(12'h040, 32'h00160010);
      gnt(6'h00, 1'b0, 3'h0);
      // slot limit off so a slot break cannot restart the chunk count
      wr(12'h040, 32'h0);
      for (int c = 0; c <= 4; c++) begin
         wr(12'h008, c);
         slow <= c[0]; wantIncr <= 6'h04; wantReq <= 6'h04;
         nb = 0; np = 0;
         repeat (200) begin
            @(posedge clk);
            if (nb < 16) nb += slaveReq[0].beat[2];
            np += burstEnd[0][2];
            if (nb == 16) wantReq <= 6'h0;
         end
         `CHK(np, expEnd[c])
      end
      report_and_stop();
   end
endmodule // test_mbsa_arbiter
